// ==== logic/timer_ctrl_cfg.svh ====
// Address map, control word fields and reset values of the timer control decoder.
// How it works
// RULE1: Bits 7:6 pick counter 0, 1 or 2; value 11 means read-back.
// RULE2: Bits 5:4 equal 00 latch the counter's count, mode untouched.
// RULE3: Bits 5:4 set access: 01 low byte, 10 high byte, 11 low then high.
// RULE4: Bits 3:1 choose one of six counting modes for the counter.
// RULE5: Field 000, 001, 100, 101 give modes 0, 1, 4, 5.
// RULE6: Top mode bit ignored; X10 is mode 2, X11 is mode 3.
// RULE7: Bit 0 clear means binary countdown, largest count two to sixteenth.
// RULE8: Bit 0 set means four-digit BCD countdown, largest ten to fourth.
// RULE9: A new count may follow any time; counter applies it per mode.
// RULE10: Each counter has its own count port, apart from control port.
// RULE11: A mode write clears the byte pointer so low byte comes next.
`ifndef TIMER_CTRL_CFG_SVH
`define TIMER_CTRL_CFG_SVH

// Port addresses: counters sit at successive addresses, control word last.
`define NUM_COUNTERS 3
`define CNT_BASE_ADDR 2'h0
`define CTRL_ADDR 2'h3

// Control word fields.
`define SEL_MSB 7
`define SEL_LSB 6
`define RW_MSB 5
`define RW_LSB 4
`define MODE_MSB 3
`define MODE_LSB 1
`define BCD_BIT 0
`define RB_MSB 5
`define SEL_READBACK 2'h3

// Count byte positions.
`define LO_MSB 7
`define LO_LSB 0
`define HI_MSB 15
`define HI_LSB 8

// Reset values of each counter's configuration and of the shared data registers.
`define RST_ACCESS 2'h3
`define RST_MODE 3'h0
`define RST_BCD 1'b0
`define RST_BYTE 8'h00
`define RST_RB 6'h00

`endif

// ==== logic/timer_ctrl_pkg.sv ====
// Types shared by the timer control decoder files.
package timer_ctrl_pkg;

    // Count port access selection, as carried in control bits 5:4.
    typedef enum logic [1:0] {
        ACC_LATCH = 2'h0,
        ACC_LO = 2'h1,
        ACC_HI = 2'h2,
        ACC_LOHI = 2'h3
    } access_t;

    // Counting modes 0 to 5.
    typedef enum logic [2:0] {
        MODE_INT_ON_TC = 3'h0,
        MODE_ONE_SHOT = 3'h1,
        MODE_RATE = 3'h2,
        MODE_SQUARE = 3'h3,
        MODE_SW_STROBE = 3'h4,
        MODE_HW_STROBE = 3'h5
    } mode_t;

endpackage : timer_ctrl_pkg

// ==== logic/mode_field_decode.sv ====
// Maps the three-bit mode field of a control word onto a counting mode.
`timescale 1ns/1ps
`default_nettype none
module mode_field_decode
    import timer_ctrl_pkg::*;
(
    // Raw mode field.
    input wire logic [2:0] field_in,
    // Decoded mode.
    output var mode_t mode_out
);

    // The top bit only matters while the low two bits are 00 or 01.
    always_comb begin
        if (field_in[1]) begin
            mode_out = field_in[0] ? MODE_SQUARE : MODE_RATE; // RULE6
        end else begin
            mode_out = mode_t'(field_in); // RULE5
        end
    end

endmodule : mode_field_decode
`default_nettype wire

// ==== logic/timer_control_decode.sv ====
// Control word decoder and count port sequencer for a three-counter timer.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_cfg.svh"
module timer_control_decode
    import timer_ctrl_pkg::*;
#(
    parameter int NUM_CNT = `NUM_COUNTERS
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port.
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // Live counts from the counting elements.
    input wire logic [NUM_CNT-1:0][15:0] count_in,
    // Per-counter configuration.
    output logic [NUM_CNT-1:0][1:0] access_out,
    output logic [NUM_CNT-1:0][2:0] mode_out,
    output logic [NUM_CNT-1:0] bcd_out,
    output logic [NUM_CNT-1:0] cfg_wr_out,
    // Commands toward the counters.
    output logic [NUM_CNT-1:0] latch_out,
    output logic readback_out,
    output logic [5:0] readback_data_out,
    // Count bytes written by software.
    output logic [NUM_CNT-1:0] count_wr_out,
    output logic count_hi_out,
    output logic [7:0] count_data_out
);

    logic ctrl_wr;
    logic [1:0] sel;
    access_t rw;
    mode_t mode_dec;
    logic [NUM_CNT-1:0] hi_sel;

    // Control word fields, split once for every counter.
    assign ctrl_wr = wr_in && (addr_in == `CTRL_ADDR);
    assign sel = wr_data_in[`SEL_MSB:`SEL_LSB];
    assign rw = access_t'(wr_data_in[`RW_MSB:`RW_LSB]);

    mode_field_decode u_mode (
        .field_in(wr_data_in[`MODE_MSB:`MODE_LSB]),
        .mode_out(mode_dec)
    );

    // Per-counter configuration and byte pointer.
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        localparam logic [1:0] PORT = `CNT_BASE_ADDR + 2'(i);
        access_t access_reg, access_next;
        mode_t mode_reg, mode_next;
        logic bcd_reg, bcd_next;
        logic ptr_reg, ptr_next;
        logic latch_reg, latch_next;
        logic cfg_reg, cfg_next;
        logic cwr_reg, cwr_next;
        logic hit, port_acc;

        // Only counter-select values 0..2 address a counter; 3 is read-back.
        assign hit = ctrl_wr && (sel != `SEL_READBACK) && (sel == PORT); // RULE1
        assign port_acc = (wr_in || rd_in) && (addr_in == PORT); // RULE10

        // High byte is addressed by a fixed high access or a raised pointer.
        assign hi_sel[i] = (access_reg == ACC_HI) ||
            (access_reg == ACC_LOHI && ptr_reg); // RULE3

        // Next configuration; a latch request leaves the mode alone.
        always_comb begin
            access_next = access_reg;
            mode_next = mode_reg;
            bcd_next = bcd_reg;
            ptr_next = ptr_reg;
            latch_next = hit && (rw == ACC_LATCH); // RULE2
            cfg_next = hit && (rw != ACC_LATCH);
            cwr_next = wr_in && (addr_in == PORT); // RULE9
            if (cfg_next) begin
                access_next = rw; // RULE3
                mode_next = mode_dec; // RULE4
                bcd_next = wr_data_in[`BCD_BIT]; // RULE7 RULE8
                ptr_next = 1'b0; // RULE11
            end else if (port_acc && access_reg == ACC_LOHI) begin
                ptr_next = !ptr_reg;
            end
        end

        // Register stage.
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                access_reg <= access_t'(`RST_ACCESS);
                mode_reg <= mode_t'(`RST_MODE);
                bcd_reg <= `RST_BCD;
                ptr_reg <= 1'b0;
                latch_reg <= 1'b0;
                cfg_reg <= 1'b0;
                cwr_reg <= 1'b0;
            end else begin
                access_reg <= access_next;
                mode_reg <= mode_next;
                bcd_reg <= bcd_next;
                ptr_reg <= ptr_next;
                latch_reg <= latch_next;
                cfg_reg <= cfg_next;
                cwr_reg <= cwr_next;
            end
        end

        assign access_out[i] = access_reg;
        assign mode_out[i] = mode_reg;
        assign bcd_out[i] = bcd_reg;
        assign latch_out[i] = latch_reg;
        assign cfg_wr_out[i] = cfg_reg;
        assign count_wr_out[i] = cwr_reg;
    end

    logic [7:0] rd_data_reg, rd_data_next;
    logic rb_reg, rb_next;
    logic [5:0] rb_data_reg, rb_data_next;
    logic hi_reg, hi_next;
    logic [7:0] cdata_reg, cdata_next;
    logic cnt_port;

    assign cnt_port = (addr_in != `CTRL_ADDR);

    // Shared outputs: read data, read-back request and written count byte.
    // The control port is write only, so reading it returns zero.
    always_comb begin
        rd_data_next = `RST_BYTE;
        rb_next = ctrl_wr && (sel == `SEL_READBACK); // RULE1
        rb_data_next = rb_data_reg;
        hi_next = hi_reg;
        cdata_next = cdata_reg;
        if (rb_next) begin
            rb_data_next = wr_data_in[`RB_MSB:0];
        end
        if (rd_in && cnt_port) begin
            rd_data_next = hi_sel[addr_in] ?
                count_in[addr_in][`HI_MSB:`HI_LSB] :
                count_in[addr_in][`LO_MSB:`LO_LSB]; // RULE3
        end
        if (wr_in && cnt_port) begin
            hi_next = hi_sel[addr_in]; // RULE3
            cdata_next = wr_data_in; // RULE9
        end
    end

    // Register stage.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_reg <= `RST_BYTE;
            rb_reg <= 1'b0;
            rb_data_reg <= `RST_RB;
            hi_reg <= 1'b0;
            cdata_reg <= `RST_BYTE;
        end else begin
            rd_data_reg <= rd_data_next;
            rb_reg <= rb_next;
            rb_data_reg <= rb_data_next;
            hi_reg <= hi_next;
            cdata_reg <= cdata_next;
        end
    end

    assign rd_data_out = rd_data_reg;
    assign readback_out = rb_reg;
    assign readback_data_out = rb_data_reg;
    assign count_hi_out = hi_reg;
    assign count_data_out = cdata_reg;

    // Checks on the decoder outputs.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_sel_route;
        ctrl_wr && sel == 2'h1 && rw != ACC_LATCH |=> cfg_wr_out == 3'h2;
    endproperty
    a_sel_route: assert property (p_sel_route) else $error("bad route"); // RULE1

    property p_readback;
        ctrl_wr && sel == `SEL_READBACK
            |=> readback_out && cfg_wr_out == 3'h0 && latch_out == 3'h0;
    endproperty
    a_readback: assert property (p_readback) else $error("bad readback"); // RULE1

    property p_latch;
        ctrl_wr && sel == 2'h2 && rw == ACC_LATCH
            |=> latch_out == 3'h4 && mode_out == $past(mode_out);
    endproperty
    a_latch: assert property (p_latch) else $error("bad latch"); // RULE2

    property p_access;
        ctrl_wr && sel == 2'h0 && rw == ACC_HI |=> access_out[0] == ACC_HI;
    endproperty
    a_access: assert property (p_access) else $error("bad access"); // RULE3

    property p_mode;
        ctrl_wr && sel == 2'h0 && rw != ACC_LATCH &&
            wr_data_in[`MODE_MSB:`MODE_LSB] == 3'h5
            |=> mode_out[0] == MODE_HW_STROBE;
    endproperty
    a_mode: assert property (p_mode) else $error("bad mode"); // RULE5

    // The field decoder sits outside the clocked logic, so it is checked here.
    property p_mode_ok;
        mode_dec <= MODE_HW_STROBE;
    endproperty
    a_mode_ok: assert property (p_mode_ok) else $error("mode range"); // RULE4

    property p_mode_one;
        ctrl_wr && sel == 2'h2 && rw != ACC_LATCH &&
            wr_data_in[`MODE_MSB:`MODE_LSB] == 3'h1
            |=> mode_out[2] == MODE_ONE_SHOT;
    endproperty
    a_mode_one: assert property (p_mode_one) else $error("bad one"); // RULE5

    property p_mode_x;
        ctrl_wr && sel == 2'h1 && rw != ACC_LATCH && wr_data_in[2]
            |=> mode_out[1] == ($past(wr_data_in[1]) ? MODE_SQUARE : MODE_RATE);
    endproperty
    a_mode_x: assert property (p_mode_x) else $error("bad x mode"); // RULE6

    property p_bcd;
        ctrl_wr && sel == 2'h0 && rw != ACC_LATCH
            |=> bcd_out[0] == $past(wr_data_in[`BCD_BIT]);
    endproperty
    a_bcd: assert property (p_bcd) else $error("bad bcd"); // RULE8

    property p_count_wr;
        wr_in && addr_in == 2'h1
            |=> count_wr_out == 3'h2 && count_data_out == $past(wr_data_in);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("bad count"); // RULE10

    property p_ptr;
        ctrl_wr && sel == 2'h0 && rw == ACC_LOHI ##1 (wr_in && addr_in == 2'h0)
            ##1 (wr_in && addr_in == 2'h0) |=> count_hi_out;
    endproperty
    a_ptr: assert property (p_ptr) else $error("bad pointer"); // RULE11

    c_readback: cover property (ctrl_wr && sel == `SEL_READBACK);
    c_latch: cover property (ctrl_wr && sel == 2'h1 && rw == ACC_LATCH);
    c_lohi: cover property (ctrl_wr && sel == 2'h0 && rw == ACC_LOHI
        ##1 (wr_in && addr_in == 2'h0) ##1 (wr_in && addr_in == 2'h0));

endmodule : timer_control_decode
`default_nettype wire

// ==== sim/interval_timer_control_word_decode_tb_top.sv ====
// Self-checking random bench for the timer control word decoder.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_control_word_decode_tb_top
    import timer_ctrl_pkg::*;
;
    logic clk_in, rst_in, wr_in, rd_in, count_hi_out, readback_out;
    logic [1:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out, count_data_out;
    logic [2:0][15:0] count_in;
    logic [2:0][1:0] access_out;
    logic [2:0][2:0] mode_out;
    logic [2:0] bcd_out, cfg_wr_out, latch_out, count_wr_out;
    logic [5:0] readback_data_out;
    logic [31:0] lfsr;
    int fails, check_count, cycles;
    // Reference model state and expected outputs.
    logic [1:0] acc_m [3];
    logic [2:0] mode_m [3];
    logic bcd_m [3], ptr_m [3];
    logic [2:0] cfg_e, latch_e, cw_e;
    logic rb_e, hi_e;
    logic [5:0] rbd_e;
    logic [7:0] cd_e, rd_e;

    timer_control_decode i_timer_control_decode (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .count_in(count_in),
        .access_out(access_out), .mode_out(mode_out), .bcd_out(bcd_out),
        .cfg_wr_out(cfg_wr_out), .latch_out(latch_out),
        .readback_out(readback_out),
        .readback_data_out(readback_data_out),
        .count_wr_out(count_wr_out), .count_hi_out(count_hi_out),
        .count_data_out(count_data_out)
    );

    // Clock at 25 MHz.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : nxt

    // Patterns X10 and X11 fold onto modes 2 and 3.
    function automatic logic [2:0] mode_of(input logic [2:0] f);
        return (f[1:0] >= 2'h2) ? {1'b0, f[1:0]} : f;
    endfunction : mode_of

    task automatic final_report;
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic check_all;
        chk("cfg_wr", cfg_e, cfg_wr_out);
        chk("latch", latch_e, latch_out);
        chk("readback", rb_e, readback_out);
        chk("readback_data", rbd_e, readback_data_out);
        for (int i = 0; i < 3; i++) begin
            chk("access", acc_m[i], access_out[i]);
            chk("mode", mode_m[i], mode_out[i]);
            chk("bcd", bcd_m[i], bcd_out[i]);
        end
        chk("count_wr", cw_e, count_wr_out);
        chk("count_hi", hi_e, count_hi_out);
        chk("count_data", cd_e, count_data_out);
        chk("rd_data", rd_e, rd_data_out);
    endtask : check_all

    // One register cycle, then the model update and a full comparison.
    task automatic op(input logic [1:0] a, input logic w, logic [7:0] d);
        logic [47:0] cv;
        logic h;
        lfsr = nxt(lfsr);
        cv = {lfsr[15:0], lfsr[31:16], lfsr[23:8]};
        @(posedge clk_in);
        addr_in <= a;
        wr_in <= w;
        rd_in <= !w;
        wr_data_in <= d;
        count_in <= cv;
        {cfg_e, latch_e, cw_e, rb_e, rd_e} = '0;
        if (a == 2'h3) begin
            if (!w) begin
                rd_e = 8'h00;
            end else if (d[7:6] == 2'h3) begin
                rb_e = 1'b1;
                rbd_e = d[5:0];
            end else if (d[5:4] == 2'h0) begin
                latch_e[d[7:6]] = 1'b1;
            end else begin
                cfg_e[d[7:6]] = 1'b1;
                acc_m[d[7:6]] = d[5:4];
                mode_m[d[7:6]] = mode_of(d[3:1]);
                bcd_m[d[7:6]] = d[0];
                ptr_m[d[7:6]] = 1'b0;
            end
        end else begin
            h = (acc_m[a] == 2'h2) || (acc_m[a] == 2'h3 && ptr_m[a]);
            if (acc_m[a] == 2'h3) begin
                ptr_m[a] = !ptr_m[a];
            end
            if (w) begin
                cw_e[a] = 1'b1;
                hi_e = h;
                cd_e = d;
            end else begin
                rd_e = h ? cv[a*16+8 +: 8] : cv[a*16 +: 8];
            end
        end
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        check_all();
    endtask : op

    // Mode write, then two count bytes with no idle cycle between strobes.
    task automatic burst(input logic [7:0] lo, logic [7:0] hi);
        @(posedge clk_in);
        addr_in <= 2'h3;
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        wr_data_in <= 8'h30;
        @(posedge clk_in);
        addr_in <= 2'h0;
        wr_data_in <= lo;
        @(posedge clk_in);
        wr_data_in <= hi;
        #1;
        chk("count_wr", 3'h1, count_wr_out);
        chk("count_hi", 1'b0, count_hi_out);
        chk("count_data", lo, count_data_out);
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
        chk("count_wr", 3'h1, count_wr_out);
        chk("count_hi", 1'b1, count_hi_out);
        chk("count_data", hi, count_data_out);
        acc_m[0] = 2'h3;
        mode_m[0] = 3'h0;
        bcd_m[0] = 1'b0;
        ptr_m[0] = 1'b0;
        hi_e = 1'b1;
        cd_e = hi;
    endtask : burst

    // Reset pulse; every output must show its reset value after release.
    task automatic reset_dut(input int n);
        rst_in <= 1'b1;
        repeat (n) @(posedge clk_in);
        rst_in <= 1'b0;
        {rbd_e, hi_e, cd_e, cfg_e, latch_e, cw_e, rb_e, rd_e} = '0;
        for (int i = 0; i < 3; i++) begin
            acc_m[i] = 2'h3;
            mode_m[i] = 3'h0;
            bcd_m[i] = 1'b0;
            ptr_m[i] = 1'b0;
        end
        @(posedge clk_in);
        #1;
        check_all();
    endtask : reset_dut

    // Hang guard: the whole run needs well under this many cycles.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles >= 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        {rst_in, addr_in, wr_data_in, wr_in, rd_in, count_in} = '0;
        rst_in = 1'b1;
        lfsr = 32'h7259;
        {fails, check_count, cycles} = '0;
        reset_dut(10);
        // Low then high sequence, then a mode write after the pair is complete.
        op(2'h3, 1'b1, 8'h36);
        op(2'h0, 1'b1, 8'h5a);
        op(2'h0, 1'b0, 8'h00);
        op(2'h3, 1'b1, 8'h37);
        op(2'h0, 1'b0, 8'h00);
        op(2'h3, 1'b1, 8'h00);
        op(2'h3, 1'b1, 8'h40);
        op(2'h3, 1'b1, 8'h80);
        burst(8'h3c, 8'hc5);
        op(2'h3, 1'b1, 8'hc2);
        // Every mode field and access kind on every counter.
        for (int i = 0; i < 24; i++) begin
            op(2'h3, 1'b1, {2'(i % 3), 2'(i / 3 % 3 + 1), 3'(i), 1'(i)});
            op(2'(i % 3), 1'b1, 8'(i * 7));
            op(2'(i % 3), 1'b0, 8'h00);
        end
        // A reset in mid-run must put every counter back to its defaults.
        reset_dut(3);
        // Random traffic over all four ports.
        for (int i = 0; i < 600; i++) begin
            lfsr = nxt(lfsr);
            op(lfsr[1:0], lfsr[2], lfsr[15:8]);
        end
        final_report();
    end
endmodule : interval_timer_control_word_decode_tb_top
`default_nettype wire
